// ---- common/cpu_seq_pkg.sv ----
package cpu_seq_pkg;

	// vector locations, low byte first
	localparam logic [15:0] VEC_NMI = 16'hfffa;
	localparam logic [15:0] VEC_RES = 16'hfffc;
	localparam logic [15:0] VEC_IRQ = 16'hfffe;

	// page numbers
	localparam logic [7:0] STACK_PAGE = 8'h01;
	localparam logic [7:0] ZERO_PAGE = 8'h00;

	// processor cycles of the reset wait (after the one reset cycle) before the vector fetch
	localparam logic [2:0] RESET_CYCLES = 3'h6;

	// idle level of the active-low pins in the synchronisers
	localparam logic [1:0] PIN_IDLE = 2'h3;

	// sequencer states
	typedef enum logic [3:0] {
		ST_RESET = 4'b0000,
		ST_RWAIT = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_FETCH = 4'b0011,
		ST_PUSH_H = 4'b0100,
		ST_PUSH_L = 4'b0101,
		ST_PUSH_P = 4'b0110,
		ST_VEC_L = 4'b0111,
		ST_VEC_H = 4'b1000,
		ST_PTR_L = 4'b1001,
		ST_PTR_H = 4'b1010
	} state_t;

	// addressing modes requested by the core
	typedef enum logic [3:0] {
		AM_IMM = 4'b0000,
		AM_ABS = 4'b0001,
		AM_ZP = 4'b0010,
		AM_ZPX = 4'b0011,
		AM_ZPY = 4'b0100,
		AM_ABSX = 4'b0101,
		AM_ABSY = 4'b0110,
		AM_REL = 4'b0111,
		AM_INDX = 4'b1000,
		AM_INDY = 4'b1001,
		AM_IND = 4'b1010
	} mode_t;

endpackage

// ---- rtl/addr_gen.sv ----
`timescale 1ns/1ps
// effective-address arithmetic, purely combinational
module addr_gen (
	// request
	input logic [3:0] mode,
	input logic [7:0] op1,
	input logic [7:0] op2,
	input logic [7:0] x,
	input logic [7:0] y,
	input logic [15:0] pc,
	// pointer bytes already read
	input logic [7:0] lo,
	input logic [7:0] hi,
	// results
	output logic [15:0] ptr,
	output logic [15:0] ptr_next,
	output logic [15:0] ea
);
	logic [7:0] zx; // page-zero sum with X, carry dropped
	logic [7:0] zy; // page-zero sum with Y, carry dropped
	logic [15:0] base; // second and third byte
	logic [15:0] ind; // pointer contents

	assign zx = op1 + x;
	assign zy = op1 + y;
	assign base = {op2, op1};
	assign ind = {hi, lo};

	// pointer locations for the indirect modes
	always_comb begin
		ptr = base;
		ptr_next = base + 16'h0001;
		case (mode)
			cpu_seq_pkg::AM_INDX: begin
				// both pointer bytes stay in page zero
				ptr = {cpu_seq_pkg::ZERO_PAGE, zx};
				ptr_next = {cpu_seq_pkg::ZERO_PAGE, zx + 8'h01};
			end
			cpu_seq_pkg::AM_INDY: begin
				ptr = {cpu_seq_pkg::ZERO_PAGE, op1};
				ptr_next = {cpu_seq_pkg::ZERO_PAGE, op1 + 8'h01};
			end
			default: begin
				ptr = base;
				ptr_next = base + 16'h0001;
			end
		endcase
	end

	// final effective address per mode
	always_comb begin
		case (mode)
			cpu_seq_pkg::AM_ABS: ea = base;
			cpu_seq_pkg::AM_ZP: ea = {cpu_seq_pkg::ZERO_PAGE, op1};
			cpu_seq_pkg::AM_ZPX: ea = {cpu_seq_pkg::ZERO_PAGE, zx};
			cpu_seq_pkg::AM_ZPY: ea = {cpu_seq_pkg::ZERO_PAGE, zy};
			cpu_seq_pkg::AM_ABSX: ea = base + {8'h00, x};
			cpu_seq_pkg::AM_ABSY: ea = base + {8'h00, y};
			// offset sign-extended onto the next-instruction address
			cpu_seq_pkg::AM_REL: ea = pc + {{8{op1[7]}}, op1};
			cpu_seq_pkg::AM_INDX: ea = ind;
			// carry from the low sum ripples into the high byte
			cpu_seq_pkg::AM_INDY: ea = ind + {8'h00, y};
			cpu_seq_pkg::AM_IND: ea = ind;
			default: ea = pc; // immediate: operand sits at pc
		endcase
	end

endmodule

// ---- rtl/exception_sequencer.sv ----
`timescale 1ns/1ps
// bus sequencer for reset, interrupt entry, opcode fetch and
// indirect address walks; one processor cycle is two clocks (three for a fetch),
// phase 1 (ph low) then phase 2 (ph high)
module exception_sequencer (
	// clock, enable, reset
	input logic CLK,
	input logic CE,
	input logic RST,
	// asynchronous pins, active low except RDY
	input logic RES_N,
	input logic IRQ_N,
	input logic NMI_N,
	input logic SO_N,
	input logic RDY,
	// system bus
	output logic [15:0] ADDR,
	input logic [7:0] DIN,
	output logic [7:0] DOUT,
	output logic WRITE,
	output logic SYNC,
	output logic PHI2,
	// core: instruction boundary and context
	input logic NEXT_REQ,
	input logic [15:0] PC_IN,
	input logic [7:0] P_IN,
	input logic [7:0] SP_IN,
	input logic I_FLAG,
	// core: address request
	input logic AG_REQ,
	input logic [3:0] AG_MODE,
	input logic [7:0] OP1,
	input logic [7:0] OP2,
	input logic [7:0] X,
	input logic [7:0] Y,
	// results to the core
	output logic [7:0] OPCODE,
	output logic OPCODE_VALID,
	output logic PC_LOAD,
	output logic [15:0] PC_NEW,
	output logic SP_LOAD,
	output logic [7:0] SP_NEW,
	output logic SET_I,
	output logic SET_V,
	output logic [15:0] EA,
	output logic EA_VALID,
	output logic [7:0] OPERAND
);

	// every flip-flop of the module
	typedef struct packed {
		cpu_seq_pkg::state_t st; // sequencer state
		logic ph; // 0 phase 1, 1 phase 2
		logic [2:0] cnt; // reset wait counter
		logic [1:0] res_q; // pin synchronisers
		logic [1:0] irq_q;
		logic [1:0] nmi_q;
		logic [1:0] so_q;
		logic [1:0] rdy_q;
		logic nmi_prev; // last phase 2 sample
		logic so_prev; // last phase 1 sample
		logic nmi_pend; // latched edge
		logic is_nmi; // vector choice of the sequence
		logic [15:0] vec; // vector being read
		logic [15:0] pc; // context held for the pushes
		logic [7:0] sp;
		logic [7:0] p;
		logic [3:0] mode; // addressing mode in progress
		logic [7:0] lo; // first byte read
		logic [15:0] addr; // bus outputs
		logic [7:0] dout;
		logic write;
		logic sync;
		logic fx; // first phase-2 clock of a fetch spent
		logic [7:0] opcode; // core outputs
		logic opvalid;
		logic pcload;
		logic [15:0] pcnew;
		logic spload;
		logic [7:0] spnew;
		logic seti;
		logic setv;
		logic [15:0] ea;
		logic eavalid;
		logic [7:0] operand;
	} regs_t;

	regs_t r; // registered state
	regs_t next_r; // next state
	logic [3:0] ag_mode; // mode fed to the arithmetic
	logic [15:0] ag_ptr; // first pointer location
	logic [15:0] ag_ptr_next; // second pointer location
	logic [15:0] ag_ea; // resulting effective address
	logic [7:0] ag_hi; // high pointer byte
	logic freeze; // read cycle held by RDY or by the fetch stretch clock
	logic adv; // end of a processor cycle
	logic res_ok; // reset pin released
	logic rdy_ok; // hold input high
	logic want_irq; // maskable request would be taken

	// a fresh request is computed from the live mode,
	// a walk in progress from the captured one
	assign ag_mode = (r.st == cpu_seq_pkg::ST_IDLE) ? AG_MODE : r.mode;
	// high pointer byte is on the bus during the last read
	// read data share this clock, so no synchroniser on DIN
	assign ag_hi = DIN;

	addr_gen u_addr_gen (
		.mode(ag_mode),
		.op1(OP1),
		.op2(OP2),
		.x(X),
		.y(Y),
		.pc(PC_IN),
		.lo(r.lo),
		.hi(ag_hi),
		.ptr(ag_ptr),
		.ptr_next(ag_ptr_next),
		.ea(ag_ea)
	);

	// only second synchroniser stages feed logic
	assign res_ok = r.res_q[1];
	assign rdy_ok = r.rdy_q[1];
	// maskable request only while the mask is clear; it is a
	// level, so the source keeps it low until the push starts
	assign want_irq = !r.irq_q[1] && !I_FLAG;

	// RDY halts read cycles only; writes run on, and the
	// reset wait counts regardless of RDY
	always_comb begin
		freeze = !r.write && !rdy_ok &&
			(r.st != cpu_seq_pkg::ST_RESET) &&
			(r.st != cpu_seq_pkg::ST_RWAIT);
		// a fetch spends one extra clock in phase 2 so that a hold
		// dropped in its phase 1 has crossed the pin synchroniser
		// before the opcode is taken; each fetch costs three clocks
		if ((r.st == cpu_seq_pkg::ST_FETCH) && r.ph && !r.fx) begin
			freeze = 1'b1;
		end
		adv = r.ph && !freeze;
	end

	// next-state logic
	always_comb begin
		next_r = r;
		// pin synchronisers
		next_r.res_q = {r.res_q[0], RES_N};
		next_r.irq_q = {r.irq_q[0], IRQ_N};
		next_r.nmi_q = {r.nmi_q[0], NMI_N};
		next_r.so_q = {r.so_q[0], SO_N};
		next_r.rdy_q = {r.rdy_q[0], RDY};
		// one-cycle strobes drop by default
		next_r.opvalid = 1'b0;
		next_r.pcload = 1'b0;
		next_r.spload = 1'b0;
		next_r.seti = 1'b0;
		next_r.setv = 1'b0;
		next_r.eavalid = 1'b0;
		// phase stays at 2 while frozen; a frozen cycle keeps its
		// address, data, write and marker; the one-cycle strobes still drop
		next_r.ph = !r.ph || freeze;
		// marks the stretch clock of a fetch; cleared outside fetch
		next_r.fx = (r.st == cpu_seq_pkg::ST_FETCH) && r.ph;

		if (!res_ok) begin
			// reset held: abort any sequence, never write
			// RDY is not looked at; the wait after release is fixed
			next_r.st = cpu_seq_pkg::ST_RESET;
			next_r.write = 1'b0;
			next_r.sync = 1'b0;
			next_r.ph = 1'b0;
		end else if (adv) begin
			case (r.st)
				// rising edge of reset seen
				cpu_seq_pkg::ST_RESET: begin
					next_r.st = cpu_seq_pkg::ST_RWAIT;
					next_r.cnt = 3'h0;
				end
				// initialisation cycles before the vector
				cpu_seq_pkg::ST_RWAIT: begin
					if (r.cnt == cpu_seq_pkg::RESET_CYCLES - 3'h1) begin
						next_r.seti = 1'b1;
						next_r.vec = cpu_seq_pkg::VEC_RES;
						next_r.addr = cpu_seq_pkg::VEC_RES;
						next_r.st = cpu_seq_pkg::ST_VEC_L;
					end else begin
						next_r.cnt = r.cnt + 3'h1;
					end
				end
				// boundary: interrupts are looked at only here
				// a boundary outranks an address request
				cpu_seq_pkg::ST_IDLE: begin
					if (NEXT_REQ) begin
						next_r.pc = PC_IN;
						next_r.sp = SP_IN;
						next_r.p = P_IN;
						if (r.nmi_pend || want_irq) begin
							// non-maskable wins, mask not consulted
							next_r.is_nmi = r.nmi_pend;
							next_r.nmi_pend = 1'b0;
							next_r.st = cpu_seq_pkg::ST_PUSH_H;
							next_r.addr = {cpu_seq_pkg::STACK_PAGE, SP_IN};
							next_r.dout = PC_IN[15:8];
							next_r.write = 1'b1;
						end else begin
							// opcode fetch with the marker up
							next_r.st = cpu_seq_pkg::ST_FETCH;
							next_r.addr = PC_IN;
							next_r.sync = 1'b1;
						end
					end else if (AG_REQ) begin
						next_r.mode = AG_MODE;
						next_r.operand = OP1;
						if ((AG_MODE == cpu_seq_pkg::AM_INDX) ||
							(AG_MODE == cpu_seq_pkg::AM_INDY) ||
							(AG_MODE == cpu_seq_pkg::AM_IND)) begin
							next_r.st = cpu_seq_pkg::ST_PTR_L;
							next_r.addr = ag_ptr;
						end else begin
							// direct modes need no bus cycle
							next_r.ea = ag_ea;
							next_r.eavalid = 1'b1;
						end
					end
				end
				// opcode arrives at the end of phase 2
				// marker drops as the opcode is handed over
				cpu_seq_pkg::ST_FETCH: begin
					next_r.opcode = DIN;
					next_r.opvalid = 1'b1;
					next_r.sync = 1'b0;
					next_r.st = cpu_seq_pkg::ST_IDLE;
				end
				// return address high, then low, then status
				cpu_seq_pkg::ST_PUSH_H: begin
					next_r.addr = {cpu_seq_pkg::STACK_PAGE,
						r.sp - 8'h01};
					next_r.dout = r.pc[7:0];
					next_r.st = cpu_seq_pkg::ST_PUSH_L;
				end
				cpu_seq_pkg::ST_PUSH_L: begin
					next_r.addr = {cpu_seq_pkg::STACK_PAGE,
						r.sp - 8'h02};
					next_r.dout = r.p;
					next_r.st = cpu_seq_pkg::ST_PUSH_P;
				end
				// pushes done: mask goes up, vector is read
				// stack pointer goes back to the core once, after all three
				cpu_seq_pkg::ST_PUSH_P: begin
					next_r.write = 1'b0;
					next_r.seti = 1'b1;
					next_r.spload = 1'b1;
					next_r.spnew = r.sp - 8'h03;
					if (r.is_nmi) begin
						next_r.vec = cpu_seq_pkg::VEC_NMI;
						next_r.addr = cpu_seq_pkg::VEC_NMI;
					end else begin
						next_r.vec = cpu_seq_pkg::VEC_IRQ;
						next_r.addr = cpu_seq_pkg::VEC_IRQ;
					end
					next_r.st = cpu_seq_pkg::ST_VEC_L;
				end
				// vectors are even, the high byte sits one up
				cpu_seq_pkg::ST_VEC_L: begin
					next_r.lo = DIN;
					next_r.addr = {r.vec[15:1], 1'b1};
					next_r.st = cpu_seq_pkg::ST_VEC_H;
				end
				// every reset and interrupt entry ends with this load
				cpu_seq_pkg::ST_VEC_H: begin
					next_r.pcload = 1'b1;
					next_r.pcnew = {DIN, r.lo};
					next_r.st = cpu_seq_pkg::ST_IDLE;
				end
				// pointer low byte, then its neighbour
				cpu_seq_pkg::ST_PTR_L: begin
					next_r.lo = DIN;
					next_r.addr = ag_ptr_next;
					next_r.st = cpu_seq_pkg::ST_PTR_H;
				end
				cpu_seq_pkg::ST_PTR_H: begin
					next_r.ea = ag_ea;
					next_r.eavalid = 1'b1;
					next_r.st = cpu_seq_pkg::ST_IDLE;
				end
				default: begin
					next_r.st = cpu_seq_pkg::ST_IDLE;
				end
			endcase
		end

		// set-overflow edge, sampled as phase 1 ends
		// no pending flag: the core sets V from the pulse itself
		if (!r.ph) begin
			next_r.so_prev = r.so_q[1];
			next_r.setv = r.so_prev && !r.so_q[1];
		end
		// edge latch placed after the clear so a new edge
		// in the clearing cycle survives
		if (r.ph) begin
			next_r.nmi_prev = r.nmi_q[1];
			if (r.nmi_prev && !r.nmi_q[1]) begin
				next_r.nmi_pend = 1'b1;
			end
		end
	end

	// single register stage; CE low holds everything
	// RST puts the edge detectors at the pins' idle level, so
	// no false edge follows reset
	always_ff @(posedge CLK) begin
		if (RST) begin
			r <= '0;
			r.st <= cpu_seq_pkg::ST_RESET;
			r.irq_q <= cpu_seq_pkg::PIN_IDLE;
			r.nmi_q <= cpu_seq_pkg::PIN_IDLE;
			r.so_q <= cpu_seq_pkg::PIN_IDLE;
			r.nmi_prev <= 1'b1;
			r.so_prev <= 1'b1;
		end else if (CE) begin
			r <= next_r;
		end
	end

	// outputs straight from the register
	// PHI2 tells bus partners which half of the cycle runs
	assign ADDR = r.addr;
	assign DOUT = r.dout;
	assign WRITE = r.write;
	assign SYNC = r.sync;
	assign PHI2 = r.ph;
	assign OPCODE = r.opcode;
	assign OPCODE_VALID = r.opvalid;
	assign PC_LOAD = r.pcload;
	assign PC_NEW = r.pcnew;
	assign SP_LOAD = r.spload;
	assign SP_NEW = r.spnew;
	assign SET_I = r.seti;
	assign SET_V = r.setv;
	assign EA = r.ea;
	assign EA_VALID = r.eavalid;
	assign OPERAND = r.operand;

endmodule

// ---- testbench/exc_seq_chk_sva.sv ----
`timescale 1ns/1ps
// pin-level checks on the exception sequencer
module exc_seq_chk (
	// clock and reset
	input logic CLK,
	input logic RST,
	// pins and core requests
	input logic RES_N,
	input logic RDY,
	input logic SO_N,
	input logic NEXT_REQ,
	input logic [3:0] AG_MODE,
	input logic [7:0] OP1,
	input logic [7:0] X,
	// bus and results
	input logic [15:0] ADDR,
	input logic WRITE,
	input logic SYNC,
	input logic PHI2,
	input logic OPCODE_VALID,
	input logic SP_LOAD,
	input logic SET_I,
	input logic SET_V,
	input logic EA_VALID,
	input logic [15:0] EA
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);
	// four low samples cover the pin synchroniser delay
	chk_rst_nowrite: assert property (!RES_N [*4] |-> !WRITE)
		else $error("write while reset held");
	chk_sync_span: assert property ($rose(SYNC) |-> !PHI2 ##1 (SYNC && PHI2))
		else $error("fetch marker not held over the cycle");
	chk_step_freeze: assert property (!RDY [*4] ##0 (SYNC && PHI2) |=>
		(SYNC && $stable(ADDR) && !OPCODE_VALID))
		else $error("fetch advanced while held");
	chk_hold_noirq: assert property (!RDY [*5] |-> !$rose(WRITE))
		else $error("sequence started while held");
	chk_entry_boundary: assert property ($rose(WRITE) |-> $past(NEXT_REQ))
		else $error("push started off a boundary");
	chk_push_first: assert property (SP_LOAD |-> SET_I && $past(WRITE, 2) &&
		(($past(ADDR, 2) & 16'hff00) == 16'h0100))
		else $error("mask or pushes out of order");
	chk_vec_pair: assert property (SP_LOAD |->
		(ADDR == 16'hfffe || ADDR == 16'hfffa) ##2 ADDR == $past(ADDR, 2) + 16'h1)
		else $error("vector address pair wrong");
	chk_so_flag: assert property ($fell(SO_N) |-> ##[1:8] SET_V)
		else $error("overflow edge not passed on");
	chk_zp_wrap: assert property (EA_VALID && AG_MODE == cpu_seq_pkg::AM_ZPX |->
		EA == {8'h00, 8'(OP1 + X)})
		else $error("zero page index left page zero");
	chk_rst_mask: assert property (SET_I && !SP_LOAD |->
		ADDR == 16'hfffc)
		else $error("reset mask not with vector fetch");
endmodule

// ---- testbench/sys_mem.sv ----
`timescale 1ns/1ps
// behavioural memory on the system bus
module sys_mem (
	// clock
	input logic CLK,
	// bus
	input logic [15:0] ADDR,
	input logic [7:0] DOUT,
	input logic WRITE,
	input logic PHI2,
	output logic [7:0] DIN
);
	// byte store, preset with an address pattern
	logic [7:0] mem [0:65535];
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'(i ^ (i >> 8) ^ 8'h5a);
		end
	end
	// outside phase 2 of a read the lines carry junk, never the data
	always_comb begin
		DIN = mem[ADDR];
		if (!PHI2 || WRITE) begin
			DIN = ~mem[ADDR];
		end
	end
	// write taken at the edge ending phase 2
	always @(posedge CLK) begin
		if (WRITE && PHI2) begin
			mem[ADDR] <= DOUT;
		end
	end
endmodule

// ---- testbench/cpu_interrupt_reset_addrgen_tb_top.sv ----
`timescale 1ns/1ps
// bench: plays the core, memory partner beside it
module cpu_interrupt_reset_addrgen_tb_top;
	// pins driven by the bench
	logic CLK = 1'b0, RST = 1'b1, CE = 1'b1, RES_N = 1'b0, RDY = 1'b1;
	logic IRQ_N = 1'b1, NMI_N = 1'b1, SO_N = 1'b1, I_FLAG = 1'b1;
	logic NEXT_REQ = 1'b0, AG_REQ = 1'b0;
	logic [3:0] AG_MODE = 4'h0;
	logic [7:0] OP1 = 8'h00, OP2 = 8'h00, X = 8'h00, Y = 8'h00;
	logic [7:0] P_IN = 8'ha5, SP_IN = 8'hfd;
	logic [15:0] PC_IN = 16'h0300;
	// design outputs
	logic [15:0] ADDR, PC_NEW, EA;
	logic [7:0] DIN, DOUT, OPCODE, SP_NEW, OPERAND;
	logic WRITE, SYNC, PHI2, OPCODE_VALID, PC_LOAD, SP_LOAD;
	logic SET_I, SET_V, EA_VALID, brk, op;
	// counters, random state
	int error_cnt = 0, n_compared = 0, nv = 0, seed = 65023;

	always #4 CLK = ~CLK;
	always_comb brk = OPCODE_VALID | PC_LOAD;
	// overflow pulses seen
	always @(posedge CLK) if (SET_V === 1'b1) nv++;

	exception_sequencer i_exception_sequencer (.*);
	sys_mem i_sys_mem (.*);

	function automatic int rnd();
		seed ^= (seed << 7) & 16'hffff;
		seed ^= seed >> 9;
		seed ^= (seed << 8) & 16'hffff;
		return seed;
	endfunction
	// memory byte as the model sees it
	function automatic logic [7:0] mb(int a);
		return i_sys_mem.mem[a & 16'hffff];
	endfunction
	task automatic cmp(string n, logic [15:0] e, logic [15:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// bounded wait for a flag, one falling edge at a time
	task automatic wt(ref logic f, output int n);
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (f !== 1'b1 && n < 300);
		cmp("in_time", 16'h1, 16'(n < 300));
	endtask
	// offer a boundary until a fetch or a vector load ends
	task automatic bnd();
		int n;
		@(negedge CLK);
		NEXT_REQ = 1'b1;
		wt(brk, n);
		op = OPCODE_VALID;
		NEXT_REQ = 1'b0;
	endtask
	// one address request with random operands
	task automatic ag(logic [3:0] m);
		int e, b, s, n;
		@(negedge CLK);
		OP1 = 8'(rnd());
		OP2 = 8'(rnd());
		X = 8'(rnd());
		Y = 8'(rnd());
		PC_IN = 16'(rnd());
		AG_MODE = m;
		AG_REQ = 1'b1;
		b = {OP2, OP1};
		s = $signed(OP1);
		case (m)
			cpu_seq_pkg::AM_IMM: e = PC_IN;
			cpu_seq_pkg::AM_ABS: e = b;
			cpu_seq_pkg::AM_ZP: e = OP1;
			cpu_seq_pkg::AM_ZPX: e = 8'(OP1 + X);
			cpu_seq_pkg::AM_ZPY: e = 8'(OP1 + Y);
			cpu_seq_pkg::AM_ABSX: e = b + X;
			cpu_seq_pkg::AM_ABSY: e = b + Y;
			cpu_seq_pkg::AM_REL: e = PC_IN + s;
			cpu_seq_pkg::AM_INDX: e = {mb(8'(OP1 + X + 1)), mb(8'(OP1 + X))};
			cpu_seq_pkg::AM_INDY: e = {mb(8'(OP1 + 1)), mb(OP1)} + Y;
			default: e = {mb(b + 1), mb(b)};
		endcase
		wt(EA_VALID, n);
		AG_REQ = 1'b0;
		cmp("ea", e[15:0], EA);
		if (m == cpu_seq_pkg::AM_IMM)
			cmp("operand", OP1, OPERAND);
	endtask

	initial begin
		int t;
		repeat (8) @(negedge CLK);
		RST = 1'b0;
		repeat (8) @(negedge CLK);
		RES_N = 1'b1;
		wt(PC_LOAD, t);
		cmp("rst_pc", {mb(16'hfffd), mb(16'hfffc)}, PC_NEW);
		cmp("rst_wait", 16'h1, 16'(t > 12));
		PC_IN = 16'h0300;
		bnd();
		cmp("fetch", 16'h1, op);
		cmp("opcode", mb(16'h0300), OPCODE);
		$display("reset and fetch test done");
		for (int k = 0; k < 33; k++) ag(4'(k % 11));
		$display("address test done");
		// masked request gives a plain fetch
		IRQ_N = 1'b0;
		repeat (4) @(negedge CLK);
		bnd();
		cmp("irq_masked", 16'h1, op);
		// unmasked, but nothing taken while held
		I_FLAG = 1'b0;
		RDY = 1'b0;
		// let the hold cross the pin synchroniser first
		repeat (4) @(negedge CLK);
		NEXT_REQ = 1'b1;
		t = ADDR;
		repeat (20) @(negedge CLK);
		cmp("held", 16'h0, WRITE | SYNC);
		cmp("held_addr", t[15:0], ADDR);
		RDY = 1'b1;
		wt(PC_LOAD, t);
		NEXT_REQ = 1'b0;
		I_FLAG = 1'b1;
		IRQ_N = 1'b1;
		cmp("irq_pc", {mb(16'hffff), mb(16'hfffe)}, PC_NEW);
		cmp("push_h", PC_IN[15:8], mb(16'h01fd));
		cmp("push_l", PC_IN[7:0], mb(16'h01fc));
		cmp("push_p", P_IN, mb(16'h01fb));
		cmp("sp", 8'hfa, SP_NEW);
		// hold dropped in the phase where the marker rose
		@(negedge CLK);
		NEXT_REQ = 1'b1;
		wt(SYNC, t);
		RDY = 1'b0;
		NEXT_REQ = 1'b0;
		repeat (12) @(negedge CLK);
		cmp("frozen_addr", PC_IN, ADDR);
		cmp("frozen_mark", 16'h1, SYNC);
		RDY = 1'b1;
		wt(OPCODE_VALID, t);
		cmp("step_op", mb(PC_IN), OPCODE);
		// non-maskable edge with mask set, line left low
		NMI_N = 1'b0;
		repeat (6) @(negedge CLK);
		bnd();
		cmp("nmi_pc", {mb(16'hfffb), mb(16'hfffa)}, PC_NEW);
		bnd();
		cmp("nmi_once", 16'h1, op);
		NMI_N = 1'b1;
		t = nv;
		SO_N = 1'b0;
		repeat (10) @(negedge CLK);
		cmp("set_v", 16'(t + 1), 16'(nv));
		SO_N = 1'b1;
		// clock enable low: the phase must not move
		t = PHI2;
		CE = 1'b0;
		repeat (5) @(negedge CLK);
		cmp("ce_hold", t[15:0], PHI2);
		CE = 1'b1;
		$display("interrupt test done");
		print_verdict();
	end
	// hang guard, far above the few hundred clocks expected
	initial begin
		#400000;
		error_cnt++;
		$display("MISMATCH watchdog exp done got hang");
		print_verdict();
	end
endmodule

// checker sees only the sequencer's ports
bind exception_sequencer exc_seq_chk i_chk (.*);
